// file: hdl/dual_channel_14bit_pwm.sv
// What this block does
// RULE1: Resolution unit is one or two clocks.
// RULE2: Base cycle is 64 or 256 units.
// RULE3: Extra pulses spread over base cycles.
// RULE4: 14-bit writable up counter, clocked per unit.
// RULE5: One counter serves both channels.
// RULE6: 12-bit use ignores top two counter bits.
// RULE7: Two 16-bit duty registers, A and B.
// RULE8: Channel A data bit zero reads one.
// RULE9: Upper 14 data bits compared with counter.
// RULE10: Out of range data holds output constant.
// RULE11: Software zeroes two low bits for 12-bit.
// RULE12: 8-bit control register, read and write.
// RULE13: 16-bit values pass an 8-bit temp.
// RULE14: 256 mode: 8 duty bits, 6 extra.
// RULE15: Extra pulse widens basic pulse one unit.
// RULE16: Control bit 7 selects test mode.
// RULE17: Control bit 6 halts counter at three.
// RULE18: Control bit 3 enables channel B pin.
// RULE19: Control bit 2 enables channel A pin.
// RULE20: Control bit 1 inverts the waveform.
// RULE21: Control bit 0 picks one or two clocks.
// RULE22: Data bit 1 picks 64 or 256 cycle.
// RULE23: Counter bit 0 steers the access window.
// RULE24: Counter wraps from all ones to zero.
// RULE25: Disabled channel drives its inactive level; the code drives the pin low even when bit 1 inverts the waveform.
`timescale 1ns/1ns
`default_nettype none

module dual_channel_14bit_pwm
   import pwm14_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [23:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   // PWM pins.
   output var  logic        pwm_a_o,
   output var  logic        pwm_b_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Pulse-division comparison, shared by both channels.
   function automatic logic chan_level(input logic [15:0] raw, input logic [13:0] cnt);
      logic [15:0] v;
      logic [13:0] d;
      logic [7:0]  rev8;
      logic [5:0]  rev6;
      logic        hit;
      logic [8:0]  thr;
      logic        lvl;
      v    = {raw[15:1], 1'b1};
      d    = raw[15:2];                                                    // RULE9
      rev8 = '0;
      rev6 = '0;
      for (int i = 0; i < 8; i++) begin
         rev8[i] = cnt[13 - i];
      end
      for (int i = 0; i < 6; i++) begin
         rev6[i] = cnt[13 - i];
      end
      // Bit reversal of the cycle index spreads the extra pulses evenly, and
      // leaves the top two counter bits meaningless when the low data bits are 0.
      if (raw[DAT_CFS]) begin                                               // RULE22
         hit = rev6 < d[5:0];                                               // RULE3 RULE6
         thr = {1'b0, d[13:6]} + {8'h00, hit};                              // RULE14 RULE15
         if (v < MIN_256) begin                                             // RULE10
            lvl = 1'b0;
         end else begin
            lvl = {1'b0, cnt[7:0]} < thr;                                   // RULE2
         end
      end else begin
         hit = rev8 < d[7:0];                                               // RULE3 RULE6
         thr = {3'b000, d[13:8]} + {8'h00, hit};                            // RULE15
         if (v < MIN_64) begin                                              // RULE10
            lvl = 1'b0;
         end else if (v > MAX_64) begin                                     // RULE10
            lvl = 1'b1;
         end else begin
            lvl = {3'b000, cnt[5:0]} < thr;                                 // RULE2
         end
      end
      return lvl;
   endfunction : chan_level

   ////////////////////////////////////////////////////////////////////////////////
   // State.
   logic [14:0] data_a_r;
   logic [14:0] data_b_r;
   logic [13:0] cnt_r;
   logic        regs_r;
   logic [7:0]  temp_r;
   logic        test_r;
   logic        halt_r;
   logic        oeb_r;
   logic        oea_r;
   logic        inv_r;
   logic        cks_r;
   logic        div_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode.
   logic        req;
   logic        wr;
   logic        rd;
   logic        hit0;
   logic        hit1;
   logic        hit2;
   logic        hit3;
   logic [7:0]  wbyte;
   logic [15:0] dat_a_full;
   logic [15:0] dat_b_full;
   logic [7:0]  ctrl_byte;
   logic        cnt_wr;
   logic        cnt_en;
   logic        cnt_hold;

   assign req        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr         = req & wb_we_i & wb_sel_i[0];
   assign rd         = req & ~wb_we_i;
   assign hit0       = wb_adr_i[23:2] == ADR_PORT0[23:2];
   assign hit1       = wb_adr_i[23:2] == ADR_PORT1[23:2];
   assign hit2       = wb_adr_i[23:2] == ADR_PORT2[23:2];
   assign hit3       = wb_adr_i[23:2] == ADR_PORT3[23:2];
   assign wbyte      = wb_dat_i[7:0];
   assign dat_a_full = {data_a_r, 1'b1};                                    // RULE8
   assign dat_b_full = {data_b_r, 1'b1};
   assign ctrl_byte  = {test_r, halt_r, CTL_RSVD_RD, oeb_r, oea_r, inv_r, cks_r};
   assign cnt_wr     = wr & hit3 & regs_r;
   assign cnt_hold   = halt_r & (cnt_r == CNT_HALT_VAL);                    // RULE17
   // Test mode counts every clock, so conversion timing is deliberately wrong.
   assign cnt_en     = test_r | ~cks_r | div_r;                             // RULE1 RULE16 RULE21

   ////////////////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait-free ack, dropped the cycle after.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (rd) begin
         wb_dat_o <= '0;
         if (hit0) begin
            wb_dat_o[7:0] <= regs_r ? ctrl_byte : dat_a_full[15:8];         // RULE12 RULE23
         end else if (hit1) begin
            wb_dat_o[7:0] <= regs_r ? BYTE_ONES : temp_r;                   // RULE13
         end else if (hit2) begin
            wb_dat_o[7:0] <= regs_r ? cnt_r[13:6] : dat_b_full[15:8];       // RULE23
         end else if (hit3) begin
            wb_dat_o[7:0] <= temp_r;                                        // RULE13
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Temporary byte: high-byte writes park here, high-byte reads load the low byte.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         temp_r <= BYTE_ZERO;
      end else if (wr & (hit2 | (hit0 & ~regs_r))) begin
         temp_r <= wbyte;                                                   // RULE13
      end else if (rd & hit0 & ~regs_r) begin
         temp_r <= dat_a_full[7:0];                                         // RULE13
      end else if (rd & hit2) begin
         temp_r <= regs_r ? {cnt_r[5:0], 1'b1, regs_r} : {data_b_r[6:0], regs_r};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Duty registers; a low-byte write commits the whole word at once.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_a_r <= DAT_RST;
      end else if (wr & hit1 & ~regs_r) begin
         data_a_r <= {temp_r, wbyte[7:1]};                                  // RULE7 RULE13
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_b_r <= DAT_RST;
      end else if (wr & hit3 & ~regs_r) begin
         data_b_r <= {temp_r, wbyte[7:1]};                                  // RULE7 RULE13
      end
   end

   // The window select bit is shared by the low bytes of data B and the counter.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         regs_r <= 1'b0;
      end else if (wr & hit3) begin
         regs_r <= wbyte[0];                                                // RULE23
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         test_r <= 1'b0;
         halt_r <= 1'b0;
         oeb_r  <= 1'b0;
         oea_r  <= 1'b0;
         inv_r  <= 1'b0;
         cks_r  <= 1'b0;
      end else if (wr & hit0 & regs_r) begin
         test_r <= wbyte[CTL_TEST];                                         // RULE12 RULE16
         halt_r <= wbyte[CTL_HALT];                                         // RULE17
         oeb_r  <= wbyte[CTL_OEB];                                          // RULE18
         oea_r  <= wbyte[CTL_OEA];                                          // RULE19
         inv_r  <= wbyte[CTL_INV];                                          // RULE20
         cks_r  <= wbyte[CTL_CKS];                                          // RULE21
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Divider and time base counter; a bus write beats a count.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_r <= 1'b0;
      end else begin
         div_r <= cks_r & ~div_r;                                           // RULE21
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= CNT_RST;
      end else if (cnt_wr) begin
         cnt_r <= {temp_r, wbyte[7:2]};                                     // RULE4 RULE13
      end else if (cnt_en & ~cnt_hold) begin
         cnt_r <= cnt_r + 14'h0001;                                         // RULE4 RULE24
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs: a disabled pin sits low whatever the phase select says.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwm_a_o <= 1'b0;
         pwm_b_o <= 1'b0;
      end else begin
         pwm_a_o <= oea_r & (chan_level(dat_a_full, cnt_r) ^ inv_r);        // RULE5 RULE19 RULE20 RULE25
         pwm_b_o <= oeb_r & (chan_level(dat_b_full, cnt_r) ^ inv_r);        // RULE5 RULE18 RULE20 RULE25
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_next_cycle_a: assert property (req |=> wb_ack_o)
      else $error("request not answered in one cycle");
   lsb_reads_one_a: assert property (rd && hit1 && !regs_r |=> wb_dat_o[0]) // RULE8
      else $error("data A bit zero did not read one");
   count_step_a: assert property (!rst_i && cnt_en && !cnt_hold && !cnt_wr   // RULE4
                                  |=> cnt_r == $past(cnt_r) + 14'h0001)
      else $error("counter did not advance");
   counter_wrap_a: assert property (cnt_r == CNT_ONES && cnt_en && !cnt_hold // RULE24
                                    && !cnt_wr |=> cnt_r == CNT_RST)
      else $error("counter did not wrap");
   halt_at_three_a: assert property (cnt_hold && !cnt_wr |=> cnt_r == CNT_HALT_VAL) // RULE17
      else $error("counter left the halt value");
   half_rate_a: assert property (cks_r && !test_r && cnt_en ##1 cks_r && !test_r // RULE21
                                 |-> !cnt_en)
      else $error("two-clock unit counted on adjacent clocks");
   gate_a_off_a: assert property (!oea_r |=> !pwm_a_o)                      // RULE19
      else $error("channel A driven while disabled");
   gate_b_off_a: assert property (!oeb_r |=> !pwm_b_o)                      // RULE18
      else $error("channel B driven while disabled");
   low_range_hold_a: assert property (oea_r && !inv_r && dat_a_full[DAT_CFS] // RULE10
                                      && dat_a_full < MIN_256 |=> !pwm_a_o)
      else $error("out of range data toggled the output");
   ctrl_readback_a: assert property (rd && hit0 && regs_r                   // RULE12
                                     |=> wb_dat_o[CTL_INV] == $past(inv_r)
                                         && wb_dat_o[CTL_HALT] == $past(halt_r))
      else $error("control byte readback mismatch");
   low_range_b_a: assert property (oeb_r && !inv_r && !dat_b_full[DAT_CFS]  // RULE10
                                   && dat_b_full < MIN_64 |=> !pwm_b_o)
      else $error("out of range data toggled channel B");
   basic_duty_a: assert property (oea_r && !inv_r && dat_a_full[DAT_CFS]    // RULE14
                                  && dat_a_full >= MIN_256
                                  && cnt_r[7:0] < dat_a_full[15:8] |=> pwm_a_o)
      else $error("channel A low inside its basic pulse");
   extra_bound_a: assert property (oea_r && !inv_r && dat_a_full[DAT_CFS]   // RULE15
                                   && cnt_r[7:0] > dat_a_full[15:8] |=> !pwm_a_o)
      else $error("channel A pulse wider than one extra unit");
   basic_duty_b_a: assert property (oeb_r && !inv_r && !dat_b_full[DAT_CFS] // RULE2
                                    && dat_b_full >= MIN_64
                                    && cnt_r[5:0] < dat_b_full[15:10] |=> pwm_b_o)
      else $error("channel B low inside its basic pulse");
   extra_bound_b_a: assert property (oeb_r && !inv_r && !dat_b_full[DAT_CFS] // RULE15
                                     && cnt_r[5:0] > dat_b_full[15:10] |=> !pwm_b_o)
      else $error("channel B pulse wider than one extra unit");
   inverted_a: assert property (oea_r && inv_r && dat_a_full[DAT_CFS]       // RULE20
                                && dat_a_full >= MIN_256
                                && cnt_r[7:0] < dat_a_full[15:8] |=> !pwm_a_o)
      else $error("inverted channel A high inside its basic pulse");

   ////////////////////////////////////////////////////////////////////////////////
   // Register access checks.
   ack_only_reply_a: assert property (!req |=> !wb_ack_o)
      else $error("ack without a request");
   ctrl_write_a: assert property (wr && hit0 && regs_r                      // RULE12
                                  |=> {oeb_r, oea_r, inv_r, cks_r}
                                      == $past({wbyte[CTL_OEB], wbyte[CTL_OEA],
                                                wbyte[CTL_INV], wbyte[CTL_CKS]}))
      else $error("control write did not land");
   window_select_a: assert property (wr && hit3 |=> regs_r == $past(wbyte[0])) // RULE23
      else $error("window bit not taken from the low byte");
   window_ones_a: assert property (rd && hit1 && regs_r                     // RULE23
                                   |=> wb_dat_o[7:0] == BYTE_ONES)
      else $error("port one did not read all ones");
   unmapped_read_a: assert property (rd && !(hit0 || hit1 || hit2 || hit3) |=> wb_dat_o == '0)
      else $error("unmapped read returned data");
   temp_park_a: assert property (wr && hit2 |=> temp_r == $past(wbyte))    // RULE13
      else $error("high byte write missed the temporary byte");
   temp_low_a: assert property (rd && hit0 && !regs_r |=> temp_r[0])        // RULE8
      else $error("data A low byte parked without bit zero set");
   temp_read_a: assert property (rd && hit3 |=> wb_dat_o[7:0] == $past(temp_r)) // RULE13
      else $error("low byte read did not return the temporary byte");
   a_high_read_a: assert property (rd && hit0 && !regs_r                    // RULE7
                                   |=> wb_dat_o[7:0] == $past(dat_a_full[15:8]))
      else $error("data A high byte readback mismatch");
   b_high_read_a: assert property (rd && hit2 && !regs_r                    // RULE7
                                   |=> wb_dat_o[7:0] == $past(dat_b_full[15:8]))
      else $error("data B high byte readback mismatch");
   cnt_high_read_a: assert property (rd && hit2 && regs_r                   // RULE23
                                     |=> wb_dat_o[7:0] == $past(cnt_r[13:6]))
      else $error("counter high byte readback mismatch");
   a_commit_a: assert property (wr && hit1 && !regs_r                       // RULE13
                                |=> dat_a_full[15:8] == $past(temp_r))
      else $error("data A commit lost the parked byte");
   b_commit_a: assert property (wr && hit3 && !regs_r                       // RULE13
                                |=> dat_b_full[15:8] == $past(temp_r))
      else $error("data B commit lost the parked byte");
   cnt_load_a: assert property (cnt_wr |=> cnt_r[13:6] == $past(temp_r))   // RULE4
      else $error("counter write lost the parked byte");

   ////////////////////////////////////////////////////////////////////////////////
   // Counter rate checks.
   test_count_a: assert property (!rst_i && test_r && !cnt_hold && !cnt_wr  // RULE16
                                  |=> cnt_r != $past(cnt_r))
      else $error("test mode counter skipped a clock");
   half_rate_on_a: assert property (cks_r && !test_r && !cnt_en ##1 cks_r && !test_r // RULE21
                                    |-> cnt_en)
      else $error("two-clock unit missed its count");
   idle_hold_a: assert property (!rst_i && !cnt_en && !cnt_wr |=> $stable(cnt_r)) // RULE1
      else $error("counter moved without a count enable");

   wrap_seen_c: cover property (cnt_r == CNT_ONES ##1 cnt_r == CNT_RST);
   pwm_a_rise_c: cover property (!pwm_a_o ##1 pwm_a_o);
   window_switch_c: cover property (!regs_r ##1 regs_r);
   halt_seen_c: cover property (cnt_hold [*3]);
   test_count_c: cover property (test_r && cnt_en);

endmodule : dual_channel_14bit_pwm

`default_nettype wire

// file: hdl/pwm14_pkg.sv
package pwm14_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus map: one byte lane per aligned word.
   localparam logic [23:0] ADR_PORT0     = 24'hffffa0;
   localparam logic [23:0] ADR_PORT1     = 24'hffffa4;
   localparam logic [23:0] ADR_PORT2     = 24'hffffa8;
   localparam logic [23:0] ADR_PORT3     = 24'hffffac;

   ////////////////////////////////////////////////////////////////////////////////
   // Control byte fields.
   localparam int          CTL_TEST      = 7;
   localparam int          CTL_HALT      = 6;
   localparam int          CTL_OEB       = 3;
   localparam int          CTL_OEA       = 2;
   localparam int          CTL_INV       = 1;
   localparam int          CTL_CKS       = 0;
   localparam logic [1:0]  CTL_RSVD_RD   = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////
   // Data and counter fields.
   localparam int          DAT_CFS       = 1;
   localparam int          CNT_W         = 14;
   localparam logic [13:0] CNT_RST       = 14'h0000;
   localparam logic [13:0] CNT_HALT_VAL  = 14'h0003;
   localparam logic [13:0] CNT_ONES      = 14'h3fff;
   localparam logic [14:0] DAT_RST       = 15'h0000;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;
   localparam logic [7:0]  BYTE_ONES     = 8'hff;

   ////////////////////////////////////////////////////////////////////////////////
   // Valid data ranges per base cycle.
   localparam logic [15:0] MIN_64        = 16'h0401;
   localparam logic [15:0] MAX_64        = 16'hfffd;
   localparam logic [15:0] MIN_256       = 16'h0103;

endpackage : pwm14_pkg

// file: dv/pwm_load_model.sv
`timescale 1ns/1ns
`default_nettype none

module pwm_load_model (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Measurement window.
   input  wire logic        clr_i,
   input  wire logic        run_i,
   // PWM pins.
   input  wire logic        pwm_a_i,
   input  wire logic        pwm_b_i,
   // Integrated high time.
   output var  logic [16:0] high_a_o,
   output var  logic [16:0] high_b_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // An ideal filter: the mean level is the high time divided by the window, so the
   // high clock count over a whole counter period is the exact figure to compare.
   always_ff @(posedge clk_i) begin
      if (rst_i || clr_i) begin
         high_a_o <= 17'h00000;
         high_b_o <= 17'h00000;
      end else if (run_i) begin
         high_a_o <= high_a_o + {16'h0000, pwm_a_i};
         high_b_o <= high_b_o + {16'h0000, pwm_b_i};
      end
   end
endmodule : pwm_load_model

`default_nettype wire

// file: dv/dual_channel_14bit_pwm_tb.sv
`timescale 1ns/1ns
`default_nettype none

module dual_channel_14bit_pwm_tb import pwm14_pkg::*;;
   logic        clk_i;
   logic        rst_i;
   logic        cyc;
   logic        we;
   logic [23:0] adr;
   logic [7:0]  wd;
   logic [31:0] rdat;
   logic        ack;
   logic        pwm_a;
   logic        pwm_b;
   logic        clr;
   logic        run;
   logic [16:0] high_a;
   logic [16:0] high_b;
   int          n_errors;
   int          samples_checked;

   dual_channel_14bit_pwm i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h000000, wd}),
      .wb_dat_o(rdat), .wb_ack_o(ack), .pwm_a_o(pwm_a), .pwm_b_o(pwm_b));

   pwm_load_model i_load (.clk_i(clk_i), .rst_i(rst_i), .clr_i(clr), .run_i(run),
      .pwm_a_i(pwm_a), .pwm_b_i(pwm_b), .high_a_o(high_a), .high_b_o(high_b));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // The request stands until ack is sampled high, so no latency is assumed.
   task automatic xfer(input logic w, input logic [23:0] a, input logic [7:0] d,
                       output logic [7:0] r);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 100);
      if (n >= 100) begin
         n_errors++;
         $display("Error at %0t ns: bus cycle not acknowledged", $time);
      end
      r = rdat[7:0];
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask : xfer

   task automatic wr(input logic [23:0] a, input logic [7:0] d);
      logic [7:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr

   task automatic rdc(input logic [23:0] a, input logic [7:0] e);
      logic [7:0] r;
      xfer(1'b0, a, 8'h00, r);
      check({9'h000, r}, {9'h000, e});
   endtask : rdc

   task automatic measure(input int n, input logic [16:0] ea, input logic [16:0] eb);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      run <= 1'b1;
      repeat (n) @(posedge clk_i);
      run <= 1'b0;
      @(posedge clk_i);
      check(high_a, ea);
      check(high_b, eb);
   endtask : measure

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   initial begin
      repeat (60000) @(posedge clk_i);
      n_errors++;
      final_report();
   end

   initial begin
      rst_i = 1'b1;
      cyc = 1'b0;
      we = 1'b0;
      adr = 24'h000000;
      wd = 8'h00;
      clr = 1'b0;
      run = 1'b0;
      n_errors = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rdc(ADR_PORT0, 8'h00);
      rdc(ADR_PORT1, 8'h01);
      wr(ADR_PORT2, 8'h00);
      wr(ADR_PORT3, 8'h01);
      rdc(ADR_PORT0, 8'h30);
      rdc(ADR_PORT1, 8'hff);
      rdc(24'hffffb0, 8'h00);
      wr(ADR_PORT0, 8'h40);
      wr(ADR_PORT2, 8'h00);
      wr(ADR_PORT3, 8'h01);
      repeat (20) @(posedge clk_i);
      rdc(ADR_PORT0, 8'h70);
      rdc(ADR_PORT2, 8'h00);
      rdc(ADR_PORT3, 8'h0f);
      wr(ADR_PORT0, 8'h00);
      wr(ADR_PORT2, 8'hff);
      wr(ADR_PORT3, 8'hfd);
      rdc(ADR_PORT2, 8'h00);
      wr(ADR_PORT0, 8'h01);
      wr(ADR_PORT2, 8'h00);
      wr(ADR_PORT3, 8'h01);
      repeat (200) @(posedge clk_i);
      rdc(ADR_PORT2, 8'h01);
      wr(ADR_PORT0, 8'h81);
      wr(ADR_PORT2, 8'h00);
      wr(ADR_PORT3, 8'h01);
      repeat (200) @(posedge clk_i);
      rdc(ADR_PORT2, 8'h03);
      wr(ADR_PORT0, 8'h00);
      wr(ADR_PORT2, 8'h00);
      wr(ADR_PORT3, 8'h01);
      repeat (200) @(posedge clk_i);
      rdc(ADR_PORT2, 8'h03);
      // Data writes need the window bit low, and the switch goes through the counter.
      wr(ADR_PORT0, 8'h0c);
      wr(ADR_PORT2, 8'h00);
      wr(ADR_PORT3, 8'h00);
      wr(ADR_PORT0, 8'h02);
      wr(ADR_PORT1, 8'h06);
      wr(ADR_PORT2, 8'h40);
      wr(ADR_PORT3, 8'h14);
      measure(16384, 17'd129, 17'd4101);
      rdc(ADR_PORT0, 8'h02);
      rdc(ADR_PORT1, 8'h07);
      rdc(ADR_PORT2, 8'h40);
      rdc(ADR_PORT3, 8'h14);
      wr(ADR_PORT2, 8'h40);
      wr(ADR_PORT3, 8'h15);
      wr(ADR_PORT0, 8'h06);
      measure(16384, 17'd16255, 17'd0);
      wr(ADR_PORT0, 8'h0c);
      wr(ADR_PORT2, 8'h00);
      wr(ADR_PORT3, 8'h00);
      wr(ADR_PORT0, 8'h00);
      wr(ADR_PORT1, 8'h02);
      wr(ADR_PORT2, 8'h01);
      wr(ADR_PORT3, 8'h00);
      measure(1024, 17'd0, 17'd0);
      final_report();
   end
endmodule : dual_channel_14bit_pwm_tb

`default_nettype wire
